/* File: pkg/lrse_regs.vh */
`ifndef LRSE_REGS_VH
`define LRSE_REGS_VH
// Instruction encodings (12-bit word)
`define LRSE_OP_NOP 12'h000
`define LRSE_OP_OPTION 12'h002
`define LRSE_OP_SLEEP 12'h003
// Opcode fields
`define LRSE_LIT_OP 4'hc
`define LRSE_RETLIT_OP 4'h8
`define LRSE_SUB_OP 6'h02
`define LRSE_RRC_OP 6'h0c
`define LRSE_RLC_OP 6'h0d
// Field positions
`define LRSE_DEST_BIT 5
`define LRSE_CARRY_BIT 0
`define LRSE_DC_BIT 1
`define LRSE_ZERO_BIT 2
`define LRSE_PD_BIT 3
`define LRSE_TO_BIT 4
// Reset values
`define LRSE_ACC_RST 8'h00
`define LRSE_OPT_RST 8'hff
`define LRSE_STAT_RST 8'h18
`define LRSE_PC_RST 9'h000
`define LRSE_WDT_RST 8'h00
`define LRSE_PRE_RST 8'h00
`endif

/* File: rtl/lrse_core.v */
`timescale 1ns/10ps
// Operation
// - Load-literal puts its 8-bit operand into the accumulator without touching flags.
// - Load-option copies the accumulator into the option register without touching flags.
// - Return-with-literal puts its 8-bit operand into the accumulator without touching flags.
// - Return-with-literal loads the program counter from the stack top entry.
// - Return-with-literal takes two cycles because the already fetched word is discarded.
// - Power-down clears the watchdog counter and its prescaler to zero.
// - Power-down sets the timeout flag, clears the power-down flag, keeps wake-on-change.
// - After power-down the core sleeps and stops executing instructions.
// - Rotate-left goes through carry and changes only the carry flag.
// - Rotate-right goes through carry and changes only the carry flag.
// - For rotate and subtract, destination bit 0 writes the accumulator, 1 the file register.
// - Subtract computes file minus accumulator and sets carry, digit carry and zero.
module lrse_core #(
	parameter ADDR_W = 5,
	parameter PC_W = 9,
	parameter STACK_W = 9
) (
	input wire i_clk,
	input wire i_nrst,
	input wire i_instr_valid,
	input wire [11:0] i_instr,
	input wire [7:0] i_file_rdata,
	input wire [STACK_W-1:0] i_stack_top_entry,
	input wire i_wdt_tick,
	input wire i_wake,
	output reg [PC_W-1:0] o_pc,
	output reg [7:0] o_acc,
	output reg [7:0] o_option,
	output reg [7:0] o_status,
	output reg [ADDR_W-1:0] o_file_addr,
	output reg [7:0] o_file_wdata,
	output reg o_file_we,
	output reg o_stack_pop,
	output reg [7:0] o_watchdog_counter,
	output reg [7:0] o_wdt_prescaler,
	output reg o_sleeping,
	output reg o_discard
);
`include "lrse_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Sequencing states
localparam [1:0] ST_RUN = 2'b00;
localparam [1:0] ST_FLUSH = 2'b01;
localparam [1:0] ST_SLEEP = 2'b10;

////////////////////////////////////////////////////////////////////////////////
// Reset asserts at once, releases two edges after the pin
reg rst_s1_q;
reg rst_s2_q;

always @(posedge i_clk or negedge i_nrst) begin
	if (!i_nrst) begin
		rst_s1_q <= 1'b0;
		rst_s2_q <= 1'b0;
	end else begin
		rst_s1_q <= 1'b1;
		rst_s2_q <= rst_s1_q;
	end
end

wire nrst;
assign nrst = rst_s2_q;

////////////////////////////////////////////////////////////////////////////////
// Wake arrives from outside the clock domain
reg wake_s1_q;
reg wake_s2_q;

always @(posedge i_clk or negedge nrst) begin
	if (!nrst) begin
		wake_s1_q <= 1'b0;
		wake_s2_q <= 1'b0;
	end else begin
		wake_s1_q <= i_wake;
		wake_s2_q <= wake_s1_q;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Sum of a, b and carry-in, with carry out of bit 3 and bit 7
function [9:0] add8;
	input [7:0] a;
	input [7:0] b;
	input cin;
	reg [4:0] lo;
	reg [4:0] hi;
	begin
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
		add8 = {hi[4], lo[4], hi[3:0], lo[3:0]};
	end
endfunction

// Wrapping increment of an 8-bit counter
function [7:0] inc8;
	input [7:0] v;
	reg [8:0] t;
	begin
		t = {1'b0, v} + 9'h001;
		inc8 = t[7:0];
	end
endfunction

// Program counter step, wraps at the top
function [PC_W-1:0] pc_next;
	input [PC_W-1:0] v;
	reg [PC_W:0] t;
	begin
		t = {1'b0, v} + {{PC_W{1'b0}}, 1'b1};
		pc_next = t[PC_W-1:0];
	end
endfunction

// Left through carry: {new carry, result}
function [8:0] rot_left;
	input [7:0] v;
	input cin;
	begin
		rot_left = {v[7], v[6:0], cin};
	end
endfunction

// Right through carry: {new carry, result}
function [8:0] rot_right;
	input [7:0] v;
	input cin;
	begin
		rot_right = {v[0], cin, v[7:1]};
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
wire is_lit;
wire is_retlit;
wire is_sub;
wire is_rlc;
wire is_rrc;
wire is_opt;
wire is_sleep;
wire dest_file;
wire old_c;
wire [9:0] sub_r;
wire [8:0] rlc_r;
wire [8:0] rrc_r;

assign is_lit = i_instr[11:8] == `LRSE_LIT_OP;
assign is_retlit = i_instr[11:8] == `LRSE_RETLIT_OP;
assign is_sub = i_instr[11:6] == `LRSE_SUB_OP;
assign is_rlc = i_instr[11:6] == `LRSE_RLC_OP;
assign is_rrc = i_instr[11:6] == `LRSE_RRC_OP;
assign is_opt = i_instr == `LRSE_OP_OPTION;
assign is_sleep = i_instr == `LRSE_OP_SLEEP;
assign dest_file = i_instr[`LRSE_DEST_BIT];
assign old_c = o_status[`LRSE_CARRY_BIT];
// Subtract as f + ~w + 1, so carry is the active-high no-borrow
assign sub_r = add8(i_file_rdata, ~o_acc, 1'b1);
assign rlc_r = rot_left(i_file_rdata, old_c);
assign rrc_r = rot_right(i_file_rdata, old_c);

////////////////////////////////////////////////////////////////////////////////
reg [7:0] res;
reg res_c;
reg wr_res;

always @* begin
	res = 8'h00;
	res_c = old_c;
	wr_res = 1'b0;
	if (is_rlc) begin
		res = rlc_r[7:0];
		res_c = rlc_r[8];
		wr_res = 1'b1;
	end else if (is_rrc) begin
		res = rrc_r[7:0];
		res_c = rrc_r[8];
		wr_res = 1'b1;
	end else if (is_sub) begin
		res = sub_r[7:0];
		res_c = sub_r[9];
		wr_res = 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Same-cycle file read needs the address straight from the word
always @* begin
	o_file_addr = i_instr[ADDR_W-1:0];
end

////////////////////////////////////////////////////////////////////////////////
reg [1:0] state_q;
reg [1:0] state_d;
reg [PC_W-1:0] pc_d;
reg [7:0] acc_d;
reg [7:0] option_d;
reg [7:0] status_d;
reg [7:0] wdata_d;
reg we_d;
reg pop_d;
reg [7:0] wdt_d;
reg [7:0] pre_d;

always @* begin
	state_d = state_q;
	pc_d = o_pc;
	acc_d = o_acc;
	option_d = o_option;
	status_d = o_status;
	wdata_d = o_file_wdata;
	we_d = 1'b0;
	pop_d = 1'b0;
	wdt_d = o_watchdog_counter;
	pre_d = o_wdt_prescaler;
	// Watchdog ticks stop with the oscillator
	if (i_wdt_tick && state_q != ST_SLEEP) begin
		pre_d = inc8(o_wdt_prescaler);
		if (o_wdt_prescaler == 8'hff)
			wdt_d = inc8(o_watchdog_counter);
	end
	case (state_q)
	ST_SLEEP: begin
		// Nothing executes until woken
		if (wake_s2_q)
			state_d = ST_RUN;
	end
	ST_FLUSH: begin
		// Flushed slot behaves as a no-op cycle
		if (i_instr_valid) begin
			state_d = ST_RUN;
			pc_d = pc_next(o_pc);
		end
	end
	ST_RUN: begin
		if (i_instr_valid) begin
			pc_d = pc_next(o_pc);
			if (is_lit) begin
				acc_d = i_instr[7:0];
			end else if (is_opt) begin
				option_d = o_acc;
			end else if (is_retlit) begin
				acc_d = i_instr[7:0];
				pc_d = i_stack_top_entry[PC_W-1:0];
				pop_d = 1'b1;
				state_d = ST_FLUSH;
			end else if (is_sleep) begin
				// Clear wins over a tick in the same cycle
				wdt_d = 8'h00;
				pre_d = 8'h00;
				status_d[`LRSE_TO_BIT] = 1'b1;
				status_d[`LRSE_PD_BIT] = 1'b0;
				state_d = ST_SLEEP;
			end else if (wr_res) begin
				status_d[`LRSE_CARRY_BIT] = res_c;
				if (is_sub) begin
					status_d[`LRSE_DC_BIT] = sub_r[8];
					status_d[`LRSE_ZERO_BIT] = (sub_r[7:0] == 8'h00);
				end
				if (dest_file) begin
					wdata_d = res;
					we_d = 1'b1;
				end else begin
					acc_d = res;
				end
			end
		end
	end
	default: begin
		state_d = ST_RUN;
	end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Sequencing
always @(posedge i_clk or negedge nrst) begin
	if (!nrst) begin
		state_q <= ST_RUN;
		o_sleeping <= 1'b0;
		o_discard <= 1'b0;
	end else begin
		state_q <= state_d;
		o_sleeping <= (state_d == ST_SLEEP);
		o_discard <= (state_d == ST_FLUSH);
	end
end

// Program counter and accumulator
always @(posedge i_clk or negedge nrst) begin
	if (!nrst) begin
		o_pc <= `LRSE_PC_RST;
		o_acc <= `LRSE_ACC_RST;
	end else begin
		o_pc <= pc_d;
		o_acc <= acc_d;
	end
end

// Option and status
always @(posedge i_clk or negedge nrst) begin
	if (!nrst) begin
		o_option <= `LRSE_OPT_RST;
		o_status <= `LRSE_STAT_RST;
	end else begin
		o_option <= option_d;
		o_status <= status_d;
	end
end

// File write and stack pop strobes last one cycle
always @(posedge i_clk or negedge nrst) begin
	if (!nrst) begin
		o_file_wdata <= 8'h00;
		o_file_we <= 1'b0;
		o_stack_pop <= 1'b0;
	end else begin
		o_file_wdata <= wdata_d;
		o_file_we <= we_d;
		o_stack_pop <= pop_d;
	end
end

// Watchdog counter and prescaler
always @(posedge i_clk or negedge nrst) begin
	if (!nrst) begin
		o_watchdog_counter <= `LRSE_WDT_RST;
		o_wdt_prescaler <= `LRSE_PRE_RST;
	end else begin
		o_watchdog_counter <= wdt_d;
		o_wdt_prescaler <= pre_d;
	end
end

endmodule

/* File: sim/lrse_fmem.sv */
`timescale 1ns/10ps
// File registers: read in the same cycle, written one cycle late
module lrse_fmem (
	input wire i_clk,
	input wire [4:0] i_addr,
	input wire i_we,
	input wire [7:0] i_wdata,
	output wire [7:0] o_rdata
);
	logic [7:0] mem [32];
	logic [4:0] a_q;
	initial for (int n = 0; n < 32; n++) mem[n] = 8'(n * 37 + 19);
	assign o_rdata = mem[i_addr];
	// Address changes with the next word, so keep the one of the writer
	always @(posedge i_clk) begin
		if (i_we) mem[a_q] <= i_wdata;
		a_q <= i_addr;
	end
endmodule

/* File: sim/lrse_core_monitor.sv */
`timescale 1ns/10ps
module lrse_core_monitor #(
	parameter PC_W = 9,
	parameter STACK_W = 9
) (
	input wire i_clk,
	input wire i_nrst,
	input wire i_instr_valid,
	input wire [11:0] i_instr,
	input wire [STACK_W-1:0] i_stack_top_entry,
	input wire i_wake,
	input wire [PC_W-1:0] o_pc,
	input wire [7:0] o_acc,
	input wire [7:0] o_option,
	input wire [7:0] o_status,
	input wire o_file_we,
	input wire [7:0] o_watchdog_counter,
	input wire [7:0] o_wdt_prescaler,
	input wire o_sleeping,
	input wire o_discard
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// Flushed or sleeping words do not execute
	sequence tk(op);
		i_instr_valid && !o_sleeping && !o_discard && op;
	endsequence
	a_nop_idle: assert property (tk(i_instr == 12'h000) |=> $stable(o_acc) &&
		$stable(o_status) && o_pc == $past(o_pc) + 1'b1) else $error("nop changed state");
	a_lit_load: assert property (tk(i_instr[11:8] == 4'hc) |=>
		o_acc == $past(i_instr[7:0]) && $stable(o_status)) else $error("literal load wrong");
	a_opt_load: assert property (tk(i_instr == 12'h002) |=> o_option == $past(o_acc))
		else $error("option load wrong");
	a_ret_jump: assert property (tk(i_instr[11:8] == 4'h8) |=>
		o_acc == $past(i_instr[7:0]) && o_pc == $past(i_stack_top_entry)) else $error("return bad");
	a_ret_flush: assert property (o_discard && i_instr_valid && !o_sleeping |=>
		!o_discard && $stable(o_acc) && o_pc == $past(o_pc) + 1'b1) else $error("no flush");
	a_sleep_clr: assert property (tk(i_instr == 12'h003) |=> o_watchdog_counter == 0 &&
		o_wdt_prescaler == 0 && o_status[4:3] == 2'b10) else $error("sleep entry wrong");
	a_sleep_halt: assert property (o_sleeping && !i_wake && !$past(i_wake) &&
		!$past(i_wake, 2) |=> o_sleeping && $stable(o_pc) && $stable(o_acc))
		else $error("sleep not halted");
	a_dest_sel: assert property (tk(i_instr[11:6] == 6'h02 || i_instr[11:7] == 5'h06) |=>
		o_file_we == $past(i_instr[5])) else $error("destination wrong");
	a_rot_flags: assert property (tk(i_instr[11:7] == 5'h06) |=>
		o_status[7:1] == $past(o_status[7:1])) else $error("rotate touched flags");
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	logic i_clk = 0, i_nrst = 0, i_instr_valid = 0, i_wdt_tick = 0, i_wake = 0;
	logic [11:0] i_instr = 0;
	logic [8:0] i_stack_top_entry = 0, p = 0;
	wire [7:0] i_file_rdata, o_acc, o_option, o_status, o_file_wdata;
	wire [7:0] o_watchdog_counter, o_wdt_prescaler;
	wire [8:0] o_pc;
	wire [4:0] o_file_addr;
	wire o_file_we, o_stack_pop, o_sleeping, o_discard;
	logic [7:0] w = 0, s = 8'h18, f, r;
	logic [11:0] i;
	int error_cnt = 0, checks_done = 0;
	lrse_core dut_u (.*);
	lrse_fmem mem_u (.i_clk(i_clk), .i_addr(o_file_addr), .i_we(o_file_we),
		.i_wdata(o_file_wdata), .o_rdata(i_file_rdata));
	initial forever #50 i_clk = ~i_clk;
	task chk(input logic [8:0] g, input logic [8:0] e);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Idle cycle after each word keeps file writes ahead of the next read
	task ex(input logic [11:0] c);
		@(negedge i_clk) i_instr = c;
		i_instr_valid = 1;
		i_wdt_tick = 1'($urandom);
		p++;
		@(negedge i_clk) i_instr_valid = 0;
		@(negedge i_clk);
	endtask
	task step(input int k, input logic [4:0] a, input logic d, input logic [7:0] x);
		f = mem_u.mem[a];
		i = k == 0 ? {4'hc, x} : {k == 1 ? 6'h02 : k == 2 ? 6'h0d : 6'h0c, d, a};
		r = k == 0 ? x : k == 1 ? f - w : k == 2 ? {f[6:0], s[0]} : {s[0], f[7:1]};
		if (k == 1) s[2:0] = {r == 0, f[3:0] >= w[3:0], f >= w};
		if (k > 1) s[0] = k == 2 ? f[7] : f[0];
		ex(i);
		if (d && k > 0) chk(9'(mem_u.mem[a]), 9'(r));
		else w = r;
		chk(9'(o_acc), 9'(w));
		chk(9'(o_status), 9'(s));
		chk(o_pc, p);
	endtask
	task results;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h6d5dcaf4));
		repeat (5) @(negedge i_clk);
		i_nrst = 1;
		repeat (3) @(negedge i_clk);
		step(0, 0, 0, 8'hff);
		step(1, 31, 1, 0);
		repeat (60) step($urandom % 4, 5'($urandom), 1'($urandom), 8'($urandom));
		ex(12'h002);
		chk(9'(o_option), 9'(w));
		ex(12'h000);
		chk(o_pc, p);
		$display("random done");
		i_stack_top_entry = 9'($urandom);
		@(negedge i_clk) i_instr = 12'h8a5;
		i_instr_valid = 1;
		@(negedge i_clk) i_instr = 12'hc3c;
		chk(9'(o_stack_pop), 9'h001);
		@(negedge i_clk) i_instr_valid = 0;
		@(negedge i_clk);
		chk(9'(o_acc), 9'h0a5);
		chk(o_pc, i_stack_top_entry + 1'b1);
		$display("return done");
		ex(12'h003);
		s[4:3] = 2'b10;
		chk(9'(o_status), 9'(s));
		chk(9'(o_watchdog_counter + o_wdt_prescaler), 0);
		ex(12'hc77);
		chk(9'(o_acc), 9'h0a5);
		i_wake = 1;
		repeat (3) @(negedge i_clk);
		i_wake = 0;
		@(negedge i_clk);
		chk(9'(o_sleeping), 9'h000);
		ex(12'hc77);
		chk(9'(o_acc), 9'h077);
		$display("sleep done");
		results;
	end
	initial begin
		#100000;
		error_cnt++;
		results;
	end
endmodule
////////////////////////////////////////////////////////////////
bind lrse_core lrse_core_monitor #(.PC_W(PC_W), .STACK_W(STACK_W)) mon_u (.*);
